// file: nsov_regs.vh
`ifndef NSOV_REGS_VH
`define NSOV_REGS_VH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define NSOV_ADDR_CTRL 8'h00
`define NSOV_ADDR_THRESH 8'h04
`define NSOV_ADDR_TRIP_DLY 8'h08
`define NSOV_ADDR_RST_DLY 8'h0C
`define NSOV_ADDR_STATUS 8'h10
`define NSOV_ADDR_PROGRESS 8'h14
`define NSOV_ADDR_OP_COUNT 8'h18
`define NSOV_ADDR_IRQ_STAT 8'h1C
`define NSOV_ADDR_IRQ_MASK 8'h20

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define NSOV_CTRL_OP_LSB 0
`define NSOV_CTRL_OP_MSB 2
`define NSOV_CTRL_MODE_LSB 4
`define NSOV_CTRL_MODE_MSB 5
`define NSOV_ST_PICKUP 0
`define NSOV_ST_TRIP 1
`define NSOV_ST_BLOCKED 2
`define NSOV_ST_ENABLED 3
`define NSOV_IRQ_PICKUP 0
`define NSOV_IRQ_TRIP 1

// ----------------------------------------------------------------
// encodings
// ----------------------------------------------------------------
`define NSOV_OP_ENABLE 3'h1
`define NSOV_OP_DISABLE 3'h5
`define NSOV_MODE_FREEZE 2'h0
`define NSOV_MODE_BLOCK_ALL 2'h1
`define NSOV_MODE_BLOCK_TRIP 2'h2
`define NSOV_RESP_OKAY 2'h0
`define NSOV_RESP_SLVERR 2'h2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define NSOV_RST_OP 3'h1
`define NSOV_RST_MODE 2'h0
`define NSOV_RST_THRESH 16'h001E
`define NSOV_RST_TRIP_DLY 20'h00028
`define NSOV_RST_RST_DLY 16'h0014
`define NSOV_RST_IRQ_MASK 2'h0

// ----------------------------------------------------------------
// timing and scaling
// ----------------------------------------------------------------
`define NSOV_CLK_PERIOD_NS 50
`define NSOV_MS_NS 1000000
`define NSOV_MS_CYCLES (`NSOV_MS_NS / `NSOV_CLK_PERIOD_NS)
`define NSOV_PCT_FULL 14'h2710

`endif

// file: nsov_pct_div.v
`include "nsov_regs.vh"

// ----------------------------------------------------------------
// progress divider: count * 10000 / delay, in hundredths of percent
// ----------------------------------------------------------------
module nsov_pct_div (
   input wire i_clk,
   input wire i_reset_n,
   input wire [19:0] i_count,
   input wire [19:0] i_delay,
   output reg [13:0] o_pct
);

reg [33:0] quo;
reg [20:0] rem;
reg [19:0] den;
reg [5:0] step;
reg busy;
wire [20:0] trial;
wire [33:0] scaled;

assign scaled = i_count * `NSOV_PCT_FULL;
assign trial = {rem[19:0], quo[33]} - {1'b0, den};

// restoring division, one quotient bit per clock, restarts when done
always @(posedge i_clk) begin
   if (!i_reset_n) begin
      quo <= 34'h000000000;
      rem <= 21'h000000;
      den <= 20'h00000;
      step <= 6'h00;
      busy <= 1'b0;
      o_pct <= 14'h0000;
   end else if (!busy) begin
      quo <= scaled;
      rem <= 21'h000000;
      den <= i_delay;
      step <= 6'h22;
      busy <= 1'b1;
   end else if (step != 6'h00) begin
      step <= step - 6'h01;
      if (!trial[20]) begin
         rem <= trial;
         quo <= {quo[32:0], 1'b1};
      end else begin
         rem <= {rem[19:0], quo[33]};
         quo <= {quo[32:0], 1'b0};
      end
   end else begin
      busy <= 1'b0;
      // clamp to full scale, also covers a zero delay
      if (quo > {20'h00000, `NSOV_PCT_FULL})
         o_pct <= `NSOV_PCT_FULL;
      else
         o_pct <= quo[13:0];
   end
end

endmodule // nsov_pct_div

// file: nsov_top.v
// Behaviour
// - operation setting enables or disables element
// - level detector compares voltage against threshold
// - pickup asserts once operation timer enabled
// - trip after definite delay while overvoltage persists
// - voltage drop before trip starts reset timer
// - reset delay expiry clears timer and pickup
// - progress percent of trip delay is readable
// - blocking mode setting selects block effect
// - freeze mode holds timer, keeps trip asserted
// - block-all disables element, resets both timers
// - block-trip mode suppresses only the trip output
// - block input inactive unless driven high
// - operation code 1 enables, 5 disables
// - progress ranges 0.00 to 100.00 percent
`include "nsov_regs.vh"

module nsov_top #(
   parameter MS_CYCLES = `NSOV_MS_CYCLES
) (
   input wire I_CLK,
   input wire I_RESET_N,
   input wire [15:0] I_NEG_SEQ_VOLTAGE_IN,
   input wire I_BLOCK,
   output reg O_PICKUP,
   output reg O_TRIP,
   output reg O_IRQ,
   input wire [7:0] I_AWADDR,
   input wire I_AWVALID,
   output reg O_AWREADY,
   input wire [31:0] I_WDATA,
   input wire [3:0] I_WSTRB,
   input wire I_WVALID,
   output reg O_WREADY,
   output reg [1:0] O_BRESP,
   output reg O_BVALID,
   input wire I_BREADY,
   input wire [7:0] I_ARADDR,
   input wire I_ARVALID,
   output reg O_ARREADY,
   output reg [31:0] O_RDATA,
   output reg [1:0] O_RRESP,
   output reg O_RVALID,
   input wire I_RREADY
);

// ----------------------------------------------------------------
// settings and state
// ----------------------------------------------------------------
reg [2:0] operation;
reg [1:0] block_mode;
reg [15:0] pickup_thresh;
reg [19:0] trip_delay;
reg [15:0] reset_delay;
reg [1:0] irq_stat;
reg [1:0] irq_mask;
reg [19:0] op_count;
reg [15:0] rst_count;
reg [15:0] tick_div;
reg ms_tick;
reg pickup_q;
reg trip_q;
wire [13:0] pickup_progress_pct;

// write channel holding
reg [7:0] aw_addr;
reg aw_held;
reg [31:0] w_data;
reg [3:0] w_strb;
reg w_held;

wire enabled;
wire blk_all;
wire blk_freeze;
wire blk_trip;
wire overvolt;
wire do_write;
wire [31:0] ctrl_word;
wire [31:0] ctrl_merged;
wire [31:0] thresh_merged;
wire [31:0] trip_merged;
wire [31:0] rstd_merged;
wire [31:0] mask_merged;

// ----------------------------------------------------------------
// protection decode
// ----------------------------------------------------------------
assign enabled = (operation == `NSOV_OP_ENABLE);
// a block effect applies only while the block pin is driven high
assign blk_all = I_BLOCK && (block_mode == `NSOV_MODE_BLOCK_ALL);
assign blk_freeze = I_BLOCK && (block_mode == `NSOV_MODE_FREEZE);
assign blk_trip = I_BLOCK && (block_mode == `NSOV_MODE_BLOCK_TRIP);
assign overvolt = (I_NEG_SEQ_VOLTAGE_IN > pickup_thresh);
assign ctrl_word = {26'h0000000, block_mode, 1'b0, operation};

// byte-lane merge for register writes
function [31:0] wr_merge;
   input [31:0] old;
   input [31:0] data;
   input [3:0] strb;
   integer b;
   begin
      wr_merge = old;
      for (b = 0; b < 4; b = b + 1) begin
         if (strb[b])
            wr_merge[8*b +: 8] = data[8*b +: 8];
      end
   end
endfunction

// byte-lane merged words of the writable registers
assign ctrl_merged = wr_merge(ctrl_word, w_data, w_strb);
assign thresh_merged = wr_merge({16'h0000, pickup_thresh}, w_data, w_strb);
assign trip_merged = wr_merge({12'h000, trip_delay}, w_data, w_strb);
assign rstd_merged = wr_merge({16'h0000, reset_delay}, w_data, w_strb);
assign mask_merged = wr_merge({30'h00000000, irq_mask}, w_data, w_strb);

// ----------------------------------------------------------------
// millisecond tick
// ----------------------------------------------------------------
always @(posedge I_CLK) begin
   if (!I_RESET_N) begin
      tick_div <= 16'h0000;
      ms_tick <= 1'b0;
   end else if (tick_div == MS_CYCLES[15:0] - 16'h0001) begin
      tick_div <= 16'h0000;
      ms_tick <= 1'b1;
   end else begin
      tick_div <= tick_div + 16'h0001;
      ms_tick <= 1'b0;
   end
end

// ----------------------------------------------------------------
// operation and reset timers, pickup and trip
// ----------------------------------------------------------------
always @(posedge I_CLK) begin
   if (!I_RESET_N || !enabled || blk_all) begin
      op_count <= 20'h00000;
      rst_count <= 16'h0000;
      pickup_q <= 1'b0;
      trip_q <= 1'b0;
   end else if (overvolt) begin
      rst_count <= 16'h0000;
      pickup_q <= 1'b1;
      if (ms_tick && !blk_freeze && op_count < trip_delay)
         op_count <= op_count + 20'h00001;
      if (blk_trip)
         trip_q <= 1'b0;
      else if (op_count >= trip_delay)
         trip_q <= 1'b1;
   end else if (trip_q && !blk_freeze) begin
      // fault gone after trip: drop at once
      op_count <= 20'h00000;
      rst_count <= 16'h0000;
      pickup_q <= 1'b0;
      trip_q <= 1'b0;
   end else if (pickup_q && !trip_q) begin
      if (rst_count >= reset_delay) begin
         op_count <= 20'h00000;
         rst_count <= 16'h0000;
         pickup_q <= 1'b0;
      end else if (ms_tick && !blk_freeze) begin
         rst_count <= rst_count + 16'h0001;
      end
   end
end

// ----------------------------------------------------------------
// output flops and interrupt
// ----------------------------------------------------------------
always @(posedge I_CLK) begin
   if (!I_RESET_N) begin
      O_PICKUP <= 1'b0;
      O_TRIP <= 1'b0;
      O_IRQ <= 1'b0;
      irq_stat <= 2'h0;
   end else begin
      O_PICKUP <= pickup_q;
      O_TRIP <= trip_q;
      O_IRQ <= |(irq_stat & irq_mask);
      // set wins over a simultaneous write-one clear
      irq_stat[`NSOV_IRQ_PICKUP] <= (pickup_q && !O_PICKUP) ||
         (irq_stat[`NSOV_IRQ_PICKUP] && !(do_write &&
         aw_addr == `NSOV_ADDR_IRQ_STAT && w_strb[0] && w_data[`NSOV_IRQ_PICKUP]));
      irq_stat[`NSOV_IRQ_TRIP] <= (trip_q && !O_TRIP) ||
         (irq_stat[`NSOV_IRQ_TRIP] && !(do_write &&
         aw_addr == `NSOV_ADDR_IRQ_STAT && w_strb[0] && w_data[`NSOV_IRQ_TRIP]));
   end
end

// ----------------------------------------------------------------
// progress divider
// ----------------------------------------------------------------
nsov_pct_div u_pct (
   .i_clk(I_CLK),
   .i_reset_n(I_RESET_N),
   .i_count(op_count),
   .i_delay(trip_delay),
   .o_pct(pickup_progress_pct)
);

// ----------------------------------------------------------------
// axi write address and data capture
// ----------------------------------------------------------------
assign do_write = aw_held && w_held && !O_BVALID;

always @(posedge I_CLK) begin
   if (!I_RESET_N) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      O_AWREADY <= 1'b0;
      O_WREADY <= 1'b0;
   end else begin
      if (I_AWVALID && O_AWREADY) begin
         aw_held <= 1'b1;
         aw_addr <= I_AWADDR;
      end else if (do_write) begin
         aw_held <= 1'b0;
      end
      if (I_WVALID && O_WREADY) begin
         w_held <= 1'b1;
         w_data <= I_WDATA;
         w_strb <= I_WSTRB;
      end else if (do_write) begin
         w_held <= 1'b0;
      end
      // ready only while nothing of that channel is pending
      O_AWREADY <= !aw_held && !(I_AWVALID && O_AWREADY) && !O_BVALID;
      O_WREADY <= !w_held && !(I_WVALID && O_WREADY) && !O_BVALID;
   end
end

// ----------------------------------------------------------------
// register writes and write response
// ----------------------------------------------------------------
always @(posedge I_CLK) begin
   if (!I_RESET_N) begin
      operation <= `NSOV_RST_OP;
      block_mode <= `NSOV_RST_MODE;
      pickup_thresh <= `NSOV_RST_THRESH;
      trip_delay <= `NSOV_RST_TRIP_DLY;
      reset_delay <= `NSOV_RST_RST_DLY;
      irq_mask <= `NSOV_RST_IRQ_MASK;
      O_BVALID <= 1'b0;
      O_BRESP <= `NSOV_RESP_OKAY;
   end else if (do_write) begin
      O_BVALID <= 1'b1;
      O_BRESP <= `NSOV_RESP_OKAY;
      if (aw_addr == `NSOV_ADDR_CTRL) begin
         {block_mode, operation} <= {ctrl_merged[`NSOV_CTRL_MODE_MSB:`NSOV_CTRL_MODE_LSB],
            ctrl_merged[`NSOV_CTRL_OP_MSB:`NSOV_CTRL_OP_LSB]};
      end else if (aw_addr == `NSOV_ADDR_THRESH) begin
         pickup_thresh <= thresh_merged[15:0];
      end else if (aw_addr == `NSOV_ADDR_TRIP_DLY) begin
         trip_delay <= trip_merged[19:0];
      end else if (aw_addr == `NSOV_ADDR_RST_DLY) begin
         reset_delay <= rstd_merged[15:0];
      end else if (aw_addr == `NSOV_ADDR_IRQ_MASK) begin
         irq_mask <= mask_merged[1:0];
      end else if (aw_addr == `NSOV_ADDR_IRQ_STAT || aw_addr == `NSOV_ADDR_STATUS ||
         aw_addr == `NSOV_ADDR_PROGRESS || aw_addr == `NSOV_ADDR_OP_COUNT) begin
         O_BRESP <= `NSOV_RESP_OKAY; // clear handled above, others read-only
      end else begin
         O_BRESP <= `NSOV_RESP_SLVERR;
      end
   end else if (O_BVALID && I_BREADY) begin
      O_BVALID <= 1'b0;
   end
end

// ----------------------------------------------------------------
// axi read channel
// ----------------------------------------------------------------
always @(posedge I_CLK) begin
   if (!I_RESET_N) begin
      O_ARREADY <= 1'b0;
      O_RVALID <= 1'b0;
      O_RDATA <= 32'h00000000;
      O_RRESP <= `NSOV_RESP_OKAY;
   end else if (I_ARVALID && O_ARREADY) begin
      O_ARREADY <= 1'b0;
      O_RVALID <= 1'b1;
      O_RRESP <= `NSOV_RESP_OKAY;
      if (I_ARADDR == `NSOV_ADDR_CTRL) begin
         O_RDATA <= ctrl_word;
      end else if (I_ARADDR == `NSOV_ADDR_THRESH) begin
         O_RDATA <= {16'h0000, pickup_thresh};
      end else if (I_ARADDR == `NSOV_ADDR_TRIP_DLY) begin
         O_RDATA <= {12'h000, trip_delay};
      end else if (I_ARADDR == `NSOV_ADDR_RST_DLY) begin
         O_RDATA <= {16'h0000, reset_delay};
      end else if (I_ARADDR == `NSOV_ADDR_STATUS) begin
         O_RDATA <= {28'h0000000, enabled, I_BLOCK, trip_q, pickup_q};
      end else if (I_ARADDR == `NSOV_ADDR_PROGRESS) begin
         O_RDATA <= {18'h00000, pickup_progress_pct};
      end else if (I_ARADDR == `NSOV_ADDR_OP_COUNT) begin
         O_RDATA <= {12'h000, op_count};
      end else if (I_ARADDR == `NSOV_ADDR_IRQ_STAT) begin
         O_RDATA <= {30'h00000000, irq_stat};
      end else if (I_ARADDR == `NSOV_ADDR_IRQ_MASK) begin
         O_RDATA <= {30'h00000000, irq_mask};
      end else begin
         O_RDATA <= 32'h00000000;
         O_RRESP <= `NSOV_RESP_SLVERR;
      end
   end else if (O_RVALID) begin
      if (I_RREADY)
         O_RVALID <= 1'b0;
   end else begin
      O_ARREADY <= 1'b1;
   end
end

endmodule // nsov_top

// file: nsov_properties.sv
// ----------------------------------------------------------------
// port checker for the protection element
// ----------------------------------------------------------------
module nsov_properties #(
   parameter MS_CYCLES = 20
) (
   input wire I_CLK,
   input wire I_RESET_N,
   input wire I_AWVALID,
   input wire O_AWREADY,
   input wire I_WVALID,
   input wire O_WREADY,
   input wire [1:0] O_BRESP,
   input wire O_BVALID,
   input wire I_BREADY,
   input wire I_ARVALID,
   input wire O_ARREADY,
   input wire [31:0] O_RDATA,
   input wire O_RVALID,
   input wire I_RREADY,
   input wire O_PICKUP,
   input wire O_TRIP,
   input wire O_IRQ
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge I_CLK); endclocking
   default disable iff (!I_RESET_N);
   // handshake steps of the register bus
   sequence s_wr_take;
      I_AWVALID && O_AWREADY && I_WVALID && O_WREADY;
   endsequence
   sequence s_rd_take;
      I_ARVALID && O_ARREADY;
   endsequence
   chk_reset_quiet:
      assert property (disable iff (1'b0) !I_RESET_N |=> !O_PICKUP && !O_TRIP && !O_IRQ)
      else $error("outputs up in reset");
   chk_trip_pickup:
      assert property (O_TRIP |-> O_PICKUP) else $error("trip without pickup");
   chk_wr_answer:
      assert property (s_wr_take |=> ##1 O_BVALID) else $error("no write response");
   chk_rd_answer:
      assert property (s_rd_take |=> O_RVALID && !O_ARREADY) else $error("no read data");
   chk_b_hold:
      assert property (O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
      else $error("write response dropped");
   chk_r_hold:
      assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
      else $error("read data dropped");
   chk_b_busy:
      assert property (O_BVALID |-> !O_AWREADY && !O_WREADY) else $error("ready during response");
   chk_r_done:
      assert property (O_RVALID && I_RREADY |=> !O_RVALID) else $error("read data repeated");
   chk_irq_source:
      assert property ($rose(O_IRQ) |-> $past(I_RESET_N)) else $error("irq after reset");
endmodule // nsov_properties

bind nsov_top nsov_properties #(.MS_CYCLES(MS_CYCLES)) u_nsov_properties (
   .I_CLK(I_CLK), .I_RESET_N(I_RESET_N), .I_AWVALID(I_AWVALID), .O_AWREADY(O_AWREADY),
   .I_WVALID(I_WVALID), .O_WREADY(O_WREADY), .O_BRESP(O_BRESP), .O_BVALID(O_BVALID),
   .I_BREADY(I_BREADY), .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY), .O_RDATA(O_RDATA),
   .O_RVALID(O_RVALID), .I_RREADY(I_RREADY), .O_PICKUP(O_PICKUP), .O_TRIP(O_TRIP),
   .O_IRQ(O_IRQ));

// file: nsov_front.sv
// ----------------------------------------------------------------
// measurement front end and breaker close interlock
// ----------------------------------------------------------------
module nsov_front (
   input wire i_clk,
   input wire [15:0] i_level,
   input wire i_pickup,
   output logic [15:0] o_v2 = 16'h0000,
   output wire o_close_inhibit
);
   timeunit 1ns;
   timeprecision 1ps;
   // one magnitude sample per clock
   always @(posedge i_clk) begin
      o_v2 <= i_level;
   end
   // keep the breaker open while unbalance is picked up
   assign o_close_inhibit = i_pickup;
endmodule // nsov_front

// file: nsov_top_tb.sv
`include "nsov_regs.vh"
module nsov_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int MS = 20;
   logic clk = 0, rst_n = 0, blk = 0, awvalid = 0, wvalid = 0, bready = 0;
   logic arvalid = 0, rready = 0;
   logic [15:0] lvl = 0;
   logic [7:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0;
   wire [15:0] v2;
   wire pickup, trip, irq, awready, wready, bvalid, arready, rvalid, inhibit;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [1:0] outs = {trip, pickup};
   logic [33:0] rq[$];
   logic [1:0] bq[$];
   int bad_count = 0, comparisons = 0;
   nsov_front u_nsov_front (.i_clk(clk), .i_level(lvl), .i_pickup(pickup), .o_v2(v2),
      .o_close_inhibit(inhibit));
   nsov_top #(.MS_CYCLES(MS)) u_nsov_top (.I_CLK(clk), .I_RESET_N(rst_n),
      .I_NEG_SEQ_VOLTAGE_IN(v2), .I_BLOCK(blk), .O_PICKUP(pickup), .O_TRIP(trip),
      .O_IRQ(irq), .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready),
      .I_WDATA(wdata), .I_WSTRB(4'hF), .I_WVALID(wvalid), .O_WREADY(wready),
      .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr),
      .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp),
      .O_RVALID(rvalid), .I_RREADY(rready));
   // ----------------------------------------------------------------
   // clock and checking helpers
   // ----------------------------------------------------------------
   initial begin
      forever #25 clk = ~clk;
   end
   task stop_test;
      $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task chk(input string what, input logic [33:0] exp, input logic [33:0] got);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task chkb(input string what, input logic e, input logic g);
      chk(what, {33'h0, e}, {33'h0, g});
   endtask
   task hold(input int c);
      repeat (c) @(posedge clk);
   endtask
   task give_up(input string what);
      $display("[ERR] %s expected answer seen none", what);
      bad_count++;
      stop_test;
   endtask
   // wait for pickup (0) or trip (1) to reach a level within a window of edges
   task wfor(input int b, input logic e, input int lo, input int hi);
      int k;
      k = 0;
      while (outs[b] !== e && k < 300) begin
         @(posedge clk);
         k++;
      end
      if (k >= 300) give_up("output level");
      else chkb("latency", 1'b1, k >= lo && k <= hi);
   endtask
   // ----------------------------------------------------------------
   // register bus master
   // ----------------------------------------------------------------
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      int n;
      bq.push_back(r);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         n++;
      end while (!bvalid && n < 50);
      bready <= 1'b0;
      if (n >= 50) give_up("write");
   endtask
   task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      int n;
      rq.push_back({r, d});
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
         n++;
      end while (!rvalid && n < 50);
      rready <= 1'b0;
      if (n >= 50) give_up("read");
   endtask
   // bus results against the oldest expectation
   always @(posedge clk) begin
      if (bvalid && bready) chk("bresp", {32'h0, bq.pop_front()}, {32'h0, bresp});
      if (rvalid && rready) chk("read", rq.pop_front(), {rresp, rdata});
   end
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   initial begin
      void'($urandom(73092));
      hold(2);
      rst_n <= 1'b1;
      rd(`NSOV_ADDR_CTRL, 32'h00000001, 2'h0);
      rd(`NSOV_ADDR_THRESH, `NSOV_RST_THRESH, 2'h0);
      rd(`NSOV_ADDR_TRIP_DLY, `NSOV_RST_TRIP_DLY, 2'h0);
      rd(`NSOV_ADDR_RST_DLY, `NSOV_RST_RST_DLY, 2'h0);
      rd(`NSOV_ADDR_IRQ_MASK, 32'h00000000, 2'h0);
      rd(8'h24, 32'h00000000, 2'h2);
      wr(8'h24, 32'h00000001, 2'h2);
      wr(`NSOV_ADDR_STATUS, 32'h0000000F, 2'h0);
      rd(`NSOV_ADDR_STATUS, 32'h00000008, 2'h0);
      // one second trip delay read back, then a 4 ms setting for the run
      wr(`NSOV_ADDR_TRIP_DLY, 32'h000003E8, 2'h0);
      rd(`NSOV_ADDR_TRIP_DLY, 32'h000003E8, 2'h0);
      wr(`NSOV_ADDR_TRIP_DLY, 32'h00000004, 2'h0);
      wr(`NSOV_ADDR_RST_DLY, 32'h00000003, 2'h0);
      wr(`NSOV_ADDR_IRQ_MASK, 32'h00000003, 2'h0);
      lvl <= 16'h001E;
      hold(10 * MS);
      chkb("pickup", 1'b0, pickup);
      lvl <= 16'h001F + 16'($urandom % 900);
      wfor(0, 1'b1, 2, 6);
      chkb("inhibit", 1'b1, inhibit);
      wfor(1, 1'b1, 3 * MS, 5 * MS + 4);
      chkb("irq", 1'b1, irq);
      hold(40);
      rd(`NSOV_ADDR_PROGRESS, 32'h00002710, 2'h0);
      rd(`NSOV_ADDR_OP_COUNT, 32'h00000004, 2'h0);
      rd(`NSOV_ADDR_IRQ_STAT, 32'h00000003, 2'h0);
      wr(`NSOV_ADDR_IRQ_STAT, 32'h00000003, 2'h0);
      hold(3);
      chkb("irq", 1'b0, irq);
      lvl <= 16'h0000;
      wfor(1, 1'b0, 1, 6);
      // short excursion: reset timer must hold pickup
      lvl <= 16'h0100;
      wfor(0, 1'b1, 2, 6);
      hold(2 * MS);
      lvl <= 16'h0000;
      hold(2 * MS - 5);
      chkb("pickup", 1'b1, pickup);
      wfor(0, 1'b0, 1, 2 * MS + 10);
      rd(`NSOV_ADDR_OP_COUNT, 32'h00000000, 2'h0);
      wr(`NSOV_ADDR_CTRL, 32'h00000005, 2'h0);
      lvl <= 16'h0100;
      hold(10 * MS);
      chk("outputs", 34'h0, {32'h0, outs});
      rd(`NSOV_ADDR_CTRL, 32'h00000005, 2'h0);
      // blocking modes
      blk <= 1'b1;
      wr(`NSOV_ADDR_CTRL, 32'h00000011, 2'h0);
      hold(10 * MS);
      chkb("pickup", 1'b0, pickup);
      rd(`NSOV_ADDR_OP_COUNT, 32'h00000000, 2'h0);
      wr(`NSOV_ADDR_CTRL, 32'h00000021, 2'h0);
      hold(10 * MS);
      chk("outputs", 34'h1, {32'h0, outs});
      blk <= 1'b0;
      wfor(1, 1'b1, 1, 6);
      wr(`NSOV_ADDR_CTRL, 32'h00000001, 2'h0);
      blk <= 1'b1;
      lvl <= 16'h0000;
      hold(10 * MS);
      chkb("trip", 1'b1, trip);
      rd(`NSOV_ADDR_OP_COUNT, 32'h00000004, 2'h0);
      blk <= 1'b0;
      wfor(1, 1'b0, 1, 6);
      stop_test;
   end
   // run limit
   initial begin
      hold(20000);
      give_up("run");
   end
endmodule // nsov_top_tb
